// ===== sts1_ptr_pkg.sv
package sts1_ptr_pkg;

   // ------------------------------------------------------------------
   // frame geometry
   // ------------------------------------------------------------------
   localparam int FRAME_ROWS = 9;
   localparam int FRAME_COLS = 90;
   localparam int TOH_COLS = 3;
   localparam int PTR_ROW = 3;
   localparam int EC_COLS = FRAME_COLS - TOH_COLS;
   localparam int EC_BYTES = FRAME_ROWS * EC_COLS;
   // envelope offset of the first payload byte of row 0
   localparam int EC_ROW0_OFF = (FRAME_ROWS - PTR_ROW) * EC_COLS;

   localparam logic [3:0] ROW_LAST = 4'(FRAME_ROWS - 1);
   localparam logic [6:0] COL_LAST = 7'(FRAME_COLS - 1);
   localparam logic [6:0] COL_H1 = 7'h00;
   localparam logic [6:0] COL_H2 = 7'h01;
   localparam logic [6:0] COL_H3 = 7'h02;
   localparam logic [6:0] COL_EC0 = 7'(TOH_COLS);
   localparam logic [3:0] ROW_PTR = 4'(PTR_ROW);

   // ------------------------------------------------------------------
   // pointer word
   // ------------------------------------------------------------------
   localparam logic [9:0] PTR_MAX = 10'h30f;
   localparam logic [9:0] PTR_WRAP = 10'(EC_BYTES - 1);
   localparam logic [9:0] PTR_ZERO = 10'h000;
   localparam logic [9:0] PTR_ROW0 = 10'(EC_ROW0_OFF);
   localparam logic [9:0] PTR_SPAN = 10'(EC_BYTES);
   localparam logic [9:0] I_BITS = 10'h2aa;
   localparam logic [9:0] D_BITS = 10'h155;
   localparam logic [3:0] NDF_NORMAL = 4'h6;
   localparam logic [1:0] SS_BITS = 2'h0;

   localparam logic [7:0] FILL_BYTE = 8'h00;

   // ------------------------------------------------------------------
   // slip buffer
   // ------------------------------------------------------------------
   localparam int SLIP_DEPTH = 16;
   localparam int SLIP_HIGH = 12;
   localparam int SLIP_LOW = 4;

   typedef enum logic [1:0] {
      ADJ_NONE,
      ADJ_INC,
      ADJ_DEC
   } adj_type;

endpackage

// ===== sts1_pointer_justification.sv
`timescale 1ns/1ps

// Function
// (R1) the frame after a positive stuff sends normal I bits and pointer + 1.
// (R2) a slip buffer that runs too full is drained by one negative stuff.
// (R3) the byte taken by a negative stuff is payload and is still sent.
// (R4) in a negative stuff frame that payload byte rides in the H3 slot.
// (R5) in a negative stuff frame the D bits of the pointer word are inverted.
// (R6) the frame after a negative stuff sends normal D bits and pointer - 1.
// (R7) each adjustment moves the envelope by exactly one byte.
// (R8) the upstream mapper sends the whole stream, clocking only DS3 bits.
// (R9) the mapper clock has a 19.3 ns pulse period, about DS3 rate on average.
// (R10) the mapper splits STS-N into STS-1s and extracts their DS3 payloads.
// (R11) a positive stuff sends a dummy byte after H3 with I bits inverted.
// (R12) pointer values above 0x30f are invalid and never used.
// (R13) frames without adjustment keep I and D normal and the pointer fixed.
module sts1_pointer_justification
   import sts1_ptr_pkg::*;
#(
   parameter int DEPTH = SLIP_DEPTH,
   parameter int HIGH_MARK = SLIP_HIGH,
   parameter int LOW_MARK = SLIP_LOW,
   parameter logic [9:0] PTR_INIT = PTR_ZERO
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic LINK_CLK,
   input wire logic [7:0] IN_DATA,
   input wire logic IN_VALID,
   output logic IN_READY,
   output logic [7:0] OUT_DATA,
   output logic OUT_SOF,
   output logic OUT_J1,
   output logic OUT_INC,
   output logic OUT_DEC,
   output logic [9:0] OUT_PTR,
   output logic UNDERRUN
);

   localparam int AW = $clog2(DEPTH);
   // out-of-range start values fall back to zero
   localparam logic [9:0] PTR_START =
      (PTR_INIT > PTR_MAX) ? PTR_ZERO : PTR_INIT; // R12
   localparam logic [9:0] SPE_START = (PTR_START <= PTR_ROW0) ?
      10'(PTR_ROW0 - PTR_START) : 10'(PTR_ROW0 + PTR_SPAN - PTR_START);
   localparam logic [AW:0] HIGH_LVL = (AW + 1)'(HIGH_MARK);
   localparam logic [AW:0] LOW_LVL = (AW + 1)'(LOW_MARK);

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      gray2bin = b;
   endfunction

   // ------------------------------------------------------------------
   // line side state, declared first as the link side reads its pointer
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [AW:0] wgray_s1;
      logic [AW:0] wgray_s2;
      logic [AW:0] rbin;
      logic [AW:0] rgray;
      logic [3:0] row;
      logic [6:0] col;
      logic [9:0] ptr;
      logic [9:0] spe_cnt;
      adj_type adj;
      logic [7:0] data;
      logic sof;
      logic j1;
      logic underrun;
   } rd_state_type;

   rd_state_type rd_reg;
   rd_state_type rd_next;

   // ------------------------------------------------------------------
   // link side: write half of the slip buffer
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [AW:0] wbin;
      logic [AW:0] wgray;
      logic [AW:0] rgray_s1;
      logic [AW:0] rgray_s2;
      logic [DEPTH-1:0][7:0] mem;
   } link_state_type;

   link_state_type lnk_reg;
   link_state_type lnk_next;
   logic link_full;

   always_comb begin
      lnk_next = lnk_reg;
      // only the gray read pointer crosses, one bit moving at a time
      lnk_next.rgray_s1 = rd_reg.rgray;
      lnk_next.rgray_s2 = lnk_reg.rgray_s1;
      // full when the pointers differ by exactly one lap
      link_full = (lnk_reg.wgray ==
         {~lnk_reg.rgray_s2[AW:AW-1],
          lnk_reg.rgray_s2[AW-2:0]});
      // a full buffer stalls the source instead of losing payload
      if (IN_VALID && !link_full) begin
         lnk_next.mem[lnk_reg.wbin[AW-1:0]] = IN_DATA;
         lnk_next.wbin = lnk_reg.wbin + 1'b1;
         lnk_next.wgray = bin2gray(lnk_next.wbin);
      end
   end

   always_ff @(posedge LINK_CLK or negedge RSTN) begin
      if (!RSTN) begin
         lnk_reg <= '0;
      end else begin
         lnk_reg <= lnk_next;
      end
   end

   assign IN_READY = !link_full;

   // ------------------------------------------------------------------
   // line side: frame builder and pointer generator
   // ------------------------------------------------------------------
   logic [AW:0] fill;
   logic [9:0] ptr_word_val;
   logic [15:0] ptr_word;
   logic frame_start;
   logic take_payload;
   logic buf_empty;

   always_comb begin
      rd_next = rd_reg;
      rd_next.wgray_s1 = lnk_reg.wgray;
      rd_next.wgray_s2 = rd_reg.wgray_s1;
      rd_next.sof = 1'b0;
      rd_next.j1 = 1'b0;
      rd_next.underrun = 1'b0;
      // fill lags the writer by the sync stages, never overstates it
      fill = gray2bin(rd_reg.wgray_s2) - rd_reg.rbin;
      buf_empty = (rd_reg.wgray_s2 == rd_reg.rgray);
      frame_start = (rd_reg.row == '0) && (rd_reg.col == '0);
      take_payload = 1'b0;

      // frame and pointer bookkeeping at the first byte of a frame
      if (frame_start) begin
         rd_next.sof = 1'b1;
         unique case (rd_reg.adj)
            ADJ_INC: begin
               // J1 landed one byte later than before
               rd_next.ptr = (rd_reg.ptr == PTR_WRAP) ?
                  PTR_ZERO : 10'(rd_reg.ptr + 1'b1); // R1 R7
               rd_next.adj = ADJ_NONE;
            end
            ADJ_DEC: begin
               rd_next.ptr = (rd_reg.ptr == PTR_ZERO) ?
                  PTR_WRAP : 10'(rd_reg.ptr - 1'b1); // R6 R7
               rd_next.adj = ADJ_NONE;
            end
            ADJ_NONE: begin
               // never two adjustments in consecutive frames, so the
               // frame after one always carries a clean pointer
               if (fill > HIGH_LVL) begin
                  rd_next.adj = ADJ_DEC; // R2
               end else if (fill < LOW_LVL) begin
                  rd_next.adj = ADJ_INC;
               end else begin
                  rd_next.adj = ADJ_NONE; // R13
               end
            end
         endcase
         // a corrupted pointer restarts at zero rather than run wild
         if (rd_next.ptr > PTR_MAX) begin
            rd_next.ptr = PTR_ZERO; // R12
         end
      end

      // ---------------------------------------------------------------
      // pointer word
      // ---------------------------------------------------------------

      // justification bits inverted as needed
      ptr_word_val = rd_reg.ptr; // R13
      if (rd_reg.adj == ADJ_INC) begin
         ptr_word_val = rd_reg.ptr ^ I_BITS; // R11
      end else if (rd_reg.adj == ADJ_DEC) begin
         ptr_word_val = rd_reg.ptr ^ D_BITS; // R5
      end
      ptr_word = {NDF_NORMAL, SS_BITS, ptr_word_val};

      // ---------------------------------------------------------------
      // byte selection for the current slot
      // ---------------------------------------------------------------

      rd_next.data = FILL_BYTE;
      if (rd_reg.col < COL_EC0) begin
         if (rd_reg.row == ROW_PTR) begin
            if (rd_reg.col == COL_H1) begin
               rd_next.data = ptr_word[15:8];
            end else if (rd_reg.col == COL_H2) begin
               rd_next.data = ptr_word[7:0];
            end else if (rd_reg.adj == ADJ_DEC) begin
               // the extra payload byte rides in H3
               take_payload = 1'b1; // R3 R4
            end
         end
      end else if ((rd_reg.row == ROW_PTR) && (rd_reg.col == COL_EC0) &&
                   (rd_reg.adj == ADJ_INC)) begin
         rd_next.data = FILL_BYTE; // R11
      end else begin
         take_payload = 1'b1;
      end

      // ---------------------------------------------------------------
      // payload slots
      // ---------------------------------------------------------------

      if (take_payload) begin
         rd_next.j1 = (rd_reg.spe_cnt == PTR_ZERO);
         rd_next.spe_cnt = (rd_reg.spe_cnt == PTR_WRAP) ?
            PTR_ZERO : 10'(rd_reg.spe_cnt + 1'b1);
         if (buf_empty) begin
            // envelope position still advances so the pointer stays true
            rd_next.underrun = 1'b1;
         end else begin
            rd_next.data = lnk_reg.mem[rd_reg.rbin[AW-1:0]];
            rd_next.rbin = rd_reg.rbin + 1'b1;
            rd_next.rgray = bin2gray(rd_next.rbin);
         end
      end

      // ---------------------------------------------------------------
      // slot counters
      // ---------------------------------------------------------------

      if (rd_reg.col == COL_LAST) begin
         rd_next.col = '0;
         rd_next.row = (rd_reg.row == ROW_LAST) ?
            4'h0 : 4'(rd_reg.row + 1'b1);
      end else begin
         rd_next.col = 7'(rd_reg.col + 1'b1);
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         // envelope count starts aligned to the starting pointer
         rd_reg <= '{wgray_s1: '0,
                     wgray_s2: '0,
                     rbin: '0,
                     rgray: '0,
                     row: '0,
                     col: '0,
                     ptr: PTR_START,
                     spe_cnt: SPE_START,
                     adj: ADJ_NONE,
                     data: FILL_BYTE,
                     sof: 1'b0,
                     j1: 1'b0,
                     underrun: 1'b0};
      end else begin
         rd_reg <= rd_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------

   assign OUT_DATA = rd_reg.data;
   assign OUT_SOF = rd_reg.sof;
   assign OUT_J1 = rd_reg.j1;
   assign OUT_INC = (rd_reg.adj == ADJ_INC);
   assign OUT_DEC = (rd_reg.adj == ADJ_DEC);
   assign OUT_PTR = rd_reg.ptr;
   assign UNDERRUN = rd_reg.underrun;

endmodule

// ===== sts1_pj_properties.sv
`timescale 1ns/1ps
module sts1_pj_checker
   import sts1_ptr_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [7:0] OUT_DATA,
   input wire logic OUT_SOF,
   input wire logic OUT_INC,
   input wire logic OUT_DEC,
   input wire logic [9:0] OUT_PTR
);
   // cycles since the last frame start
   logic [9:0] cnt_reg;
   logic [9:0] m;
   assign m = OUT_INC ? I_BITS : (OUT_DEC ? D_BITS : 10'h000);
   always_ff @(posedge CLK or negedge RSTN)
      if (!RSTN) cnt_reg <= 10'h000;
      else cnt_reg <= OUT_SOF ? 10'h001 : cnt_reg + 10'h001;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_stuff_excl: assert property (!(OUT_INC && OUT_DEC))
      else $error("inc and dec together");
   a_ptr_range: assert property (OUT_PTR <= PTR_MAX)
      else $error("pointer out of range");
   a_ptr_inc: assert property (OUT_SOF && $past(OUT_INC) |-> OUT_PTR ==
      ($past(OUT_PTR) == PTR_WRAP ? PTR_ZERO : $past(OUT_PTR) + 10'h001))
      else $error("pointer not incremented");
   a_ptr_dec: assert property (OUT_SOF && $past(OUT_DEC) |-> OUT_PTR ==
      ($past(OUT_PTR) == PTR_ZERO ? PTR_WRAP : $past(OUT_PTR) - 10'h001))
      else $error("pointer not decremented");
   a_ptr_hold: assert property
      (!(OUT_SOF && $past(OUT_INC || OUT_DEC)) |-> $stable(OUT_PTR))
      else $error("pointer moved without stuff");
   a_frame_len: assert property (cnt_reg == 10'd810 |-> OUT_SOF)
      else $error("frame start missing");
   a_h1_word: assert property (cnt_reg == 10'd270 |-> OUT_DATA ==
      {NDF_NORMAL, SS_BITS, OUT_PTR[9:8] ^ m[9:8]})
      else $error("bad first pointer byte");
   a_h2_byte: assert property (cnt_reg == 10'd271 |->
      OUT_DATA == (OUT_PTR[7:0] ^ m[7:0]))
      else $error("bad second pointer byte");
   a_h3_idle: assert property (cnt_reg == 10'd272 && !OUT_DEC |->
      OUT_DATA == FILL_BYTE) else $error("h3 not idle");
   a_inc_dummy: assert property (cnt_reg == 10'd273 && OUT_INC |->
      OUT_DATA == FILL_BYTE) else $error("stuff byte not dummy");
endmodule
bind sts1_pointer_justification sts1_pj_checker u_sts1_pj_checker (
   .CLK(CLK), .RSTN(RSTN), .OUT_DATA(OUT_DATA), .OUT_SOF(OUT_SOF),
   .OUT_INC(OUT_INC), .OUT_DEC(OUT_DEC), .OUT_PTR(OUT_PTR));

// ===== link_source.sv
`timescale 1ns/1ps
module link_source (
   input wire logic LINK_CLK,
   input wire logic RSTN,
   input wire logic EN,
   input wire logic IN_READY,
   output logic [7:0] IN_DATA = 8'hff,
   output logic IN_VALID = 1'b0
);
   logic [7:0] seq = 8'h00;
   // payload bytes only, in order; idle data toggles so it is never reused
   always @(posedge LINK_CLK or negedge RSTN) begin
      if (!RSTN) begin
         IN_VALID <= 1'b0;
         seq <= 8'h00;
      end else if (IN_VALID && !IN_READY) begin
      end else if (EN) begin
         IN_DATA <= seq;
         IN_VALID <= 1'b1;
         seq <= seq + 8'h01;
      end else begin
         IN_VALID <= 1'b0;
         IN_DATA <= ~IN_DATA;
      end
   end
endmodule

// ===== sts1_pointer_justification_test.sv
`timescale 1ns/1ps
module sts1_pointer_justification_test
   import sts1_ptr_pkg::*;
;
   logic CLK = 0, LINK_CLK = 0, RSTN = 0, en = 0, adj_prev = 0;
   logic [7:0] IN_DATA, OUT_DATA, exp_byte = 8'h00;
   logic IN_VALID, IN_READY, OUT_SOF, OUT_J1, OUT_INC, OUT_DEC, UNDERRUN;
   logic [9:0] OUT_PTR, d_ptr, p_exp;
   logic [7:0] d_data;
   logic d_ready, d_sof, d_j1, d_inc, d_dec, d_under;
   int failures = 0, n_tests = 0, cnt = 0, n_inc = 0, n_pay = 0, row, col;
   always #20 CLK = ~CLK;
   initial #17 forever #62.5 LINK_CLK = ~LINK_CLK;
   sts1_pointer_justification u_sts1_pointer_justification (.CLK(CLK),
      .RSTN(RSTN), .LINK_CLK(LINK_CLK), .IN_DATA(IN_DATA),
      .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_DATA(OUT_DATA),
      .OUT_SOF(OUT_SOF), .OUT_J1(OUT_J1), .OUT_INC(OUT_INC),
      .OUT_DEC(OUT_DEC), .OUT_PTR(OUT_PTR), .UNDERRUN(UNDERRUN));
   // zero marks: any byte waiting at frame start forces a negative stuff
   sts1_pointer_justification #(.HIGH_MARK(0), .LOW_MARK(0))
      u_sts1_pointer_justification_dec (.CLK(CLK), .RSTN(RSTN),
      .LINK_CLK(LINK_CLK), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID),
      .IN_READY(d_ready), .OUT_DATA(d_data), .OUT_SOF(d_sof),
      .OUT_J1(d_j1), .OUT_INC(d_inc), .OUT_DEC(d_dec), .OUT_PTR(d_ptr),
      .UNDERRUN(d_under));
   link_source u_link_source (.LINK_CLK(LINK_CLK), .RSTN(RSTN), .EN(en),
      .IN_READY(IN_READY), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID));
   task check(input string what, input logic [15:0] exp, got);
      n_tests++;
      if (exp !== got) begin
         failures++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // slot tracker; payload must come out whole and in order
   always @(negedge CLK) if (RSTN) begin
      cnt = OUT_SOF ? 0 : cnt + 1;
      row = cnt / 90;
      col = cnt % 90;
      if (OUT_SOF) begin
         if (adj_prev) check("adjust twice", 16'h0, {OUT_INC, OUT_DEC});
         adj_prev = OUT_INC | OUT_DEC;
         n_inc += OUT_INC;
      end
      if (OUT_J1 && !adj_prev)
         check("j1 offset", 16'(OUT_PTR), 16'((row+6)%9*87+col-3));
      if (((col > 2 && !(cnt == 273 && OUT_INC)) || (cnt == 272 && OUT_DEC))
          && UNDERRUN === 1'b0) begin
         check("payload", 16'(exp_byte), 16'(OUT_DATA));
         exp_byte++;
         n_pay++;
      end
   end
   task reset_values;
      check("reset ptr", 16'(PTR_ZERO), 16'(OUT_PTR));
      check("reset ready", 16'h1, 16'(IN_READY));
      check("reset stuff", 16'h0, {OUT_INC, OUT_DEC});
   endtask
   // writer far slower than line side: buffer runs dry, stuffs follow
   task stream_run;
      en <= 1;
      for (int i = 0; i < 4000 && n_inc < 2; i++) @(negedge CLK);
      check("inc frames", 16'h1, 16'(n_inc >= 2));
      if (n_inc < 2) finish_test;
   endtask
   // stall mid-stream then resume: no byte may be lost or repeated
   task stall_run;
      int p;
      en <= 0;
      repeat (1620) @(negedge CLK);
      p = n_pay;
      en <= 1;
      repeat (1620) @(negedge CLK);
      check("resumed", 16'h1, 16'(n_pay > p + 100));
      check("ptr valid", 16'h1, 16'(OUT_PTR <= PTR_MAX));
   endtask
   // negative stuff: D bits inverted, then pointer one lower
   task dec_run;
      logic [9:0] p;
      logic [15:0] e;
      int i;
      i = 0;
      while (i < 8100 && !(d_sof && d_dec)) begin
         @(negedge CLK);
         i++;
      end
      check("dec frame", 16'h1, 16'(d_sof && d_dec));
      if (!(d_sof && d_dec)) finish_test;
      p = d_ptr;
      repeat (270) @(negedge CLK);
      e = {8'h00, NDF_NORMAL, SS_BITS, p[9:8] ^ D_BITS[9:8]};
      check("dec h1", e, 16'(d_data));
      @(negedge CLK);
      check("dec h2", 16'(p[7:0] ^ D_BITS[7:0]), 16'(d_data));
      repeat (539) @(negedge CLK);
      check("dec sof", 16'h1, 16'(d_sof));
      p_exp = (p == PTR_ZERO) ? PTR_WRAP : 10'(p - 10'h001);
      check("dec ptr", 16'(p_exp), 16'(d_ptr));
      check("dec clear", 16'h0, {d_inc, d_dec});
   endtask
   initial begin
      repeat (8) @(negedge CLK);
      reset_values;
      RSTN <= 1;
      stream_run;
      stall_run;
      dec_run;
      finish_test;
   end
endmodule
